//--- core/srg_device.sv
// register device end of the serial link: frame receive, reply shift,
// diagnostic latch and the four floating gate driver controls
// assumes link pins are asynchronous and sck is far slower than sys_clk
// limitation: each reply carries the answer to the frame before it
`timescale 1ns/1ps
`default_nettype none
module srg_device (
	input wire logic sys_clk,
	input wire logic nrst,
	srg_link_if.dev link,
	input wire logic [srg_pkg::NUM_FAULTS-1:0] fault_src,
	input wire logic main_rail_fault,
	output logic [srg_pkg::NUM_GATES-1:0] gate_drive_out,
	output logic fault_output_n,
	output logic main_rail_reset_n,
	output logic serial_error_flag
);
	import srg_pkg::*;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] prev;
		logic [NUM_FAULTS:0] f1;
		logic [NUM_FAULTS:0] f2;
		logic [FRAME_BITS-1:0] rx;
		logic [4:0] cnt;
		logic [FRAME_BITS-1:0] tx;
		logic sdo_oe;
		logic last_wr;
		logic [ADDR_W-1:0] last_addr;
		logic [NUM_BANKS-1:0][DATA_W-1:0] bank;
		logic [DATA_W-1:0] diag;
		logic ffo_n;
		logic rail_n;
	} srg_dev_st_t;

	localparam srg_dev_st_t DEV_RST = '{
		s1: SYNC_IDLE,
		s2: SYNC_IDLE,
		prev: SYNC_IDLE,
		ffo_n: 1'b1,
		default: '0
	};

	srg_dev_st_t st_r;
	srg_dev_st_t st_nxt;

	logic stb_low;
	logic stb_fall;
	logic stb_rise;
	logic sck_rise;
	logic sck_fall;
	logic ff;
	logic commit;
	logic frame_err;
	logic rx_wr;
	logic [ADDR_W-1:0] rx_addr;
	logic [DATA_W-1:0] rx_data;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] status_byte;
	logic [FRAME_BITS-2:0] reply_body;

	// edges come from the second stage and its delayed copy only
	assign stb_low = ~st_r.s2[IX_STB];
	assign stb_fall = st_r.prev[IX_STB] & ~st_r.s2[IX_STB];
	assign stb_rise = ~st_r.prev[IX_STB] & st_r.s2[IX_STB];
	assign sck_rise = ~st_r.prev[IX_SCK] & st_r.s2[IX_SCK];
	assign sck_fall = st_r.prev[IX_SCK] & ~st_r.s2[IX_SCK];

	// fault flag is the or of the whole diagnostic byte, so it clears with it
	assign ff = |st_r.diag;
	assign rx_wr = st_r.rx[WR_BIT];
	assign rx_addr = st_r.rx[ADDR_MSB:ADDR_LSB];
	assign rx_data = st_r.rx[DATA_MSB:DATA_LSB];

	// good frame needs exactly sixteen rises and odd weight overall
	assign commit = stb_rise & (st_r.cnt == CNT_FULL) & (^st_r.rx);
	assign frame_err = stb_rise & ~commit;

	// rail fault takes bit 6; the top live fault input does not fit the byte
	assign status_byte = {ff, st_r.f2[NUM_FAULTS], st_r.f2[NUM_FAULTS-2:0]};

	always_comb
	begin
		// addresses at or above the limit read back as zero
		rd_data = '0;
		if (st_r.last_addr == ADDR_STATUS)
		begin
			rd_data = status_byte;
		end
		else if (st_r.last_addr == ADDR_DIAG)
		begin
			rd_data = st_r.diag;
		end
		else if (st_r.last_addr < ADDR_LIMIT)
		begin
			rd_data = st_r.bank[st_r.last_addr[3:0]];
		end
	end

	// reply reflects the previous committed frame; fault flag always leads
	assign reply_body = {ff, 6'h00, st_r.last_wr ? st_r.diag : rd_data};

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = {link.sdi, link.sck, link.serial_strobe_n};
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		// fault inputs are asynchronous levels: two stages before any use
		st_nxt.f1 = {main_rail_fault, fault_src};
		st_nxt.f2 = st_r.f1;

		if (stb_low && sck_rise)
		begin
			st_nxt.rx = {st_r.rx[FRAME_BITS-2:0], st_r.s2[IX_SDI]};
			// saturate so any extra edge still reads as too many
			if (st_r.cnt != CNT_OVER)
			begin
				st_nxt.cnt = st_r.cnt + 5'h01;
			end
		end
		// count restarts at every frame end, good or bad
		if (stb_rise)
		begin
			st_nxt.cnt = '0;
		end

		// enable follows the synchronised strobe, so release lags the pin
		st_nxt.sdo_oe = stb_low;
		if (stb_fall)
		begin
			st_nxt.tx = {reply_body, srg_odd_par(reply_body)};
		end
		else if (stb_low && sck_fall)
		begin
			st_nxt.tx = {st_r.tx[FRAME_BITS-2:0], 1'b0};
		end

		// set wins: a fault in the commit cycle survives the reset
		st_nxt.diag = (commit ? '0 : st_r.diag) | {st_r.f2[NUM_FAULTS-1:0], 1'b0};
		// serial error survives a failed frame; only a good frame clears it
		if (frame_err)
		begin
			st_nxt.diag[DIAG_SE] = 1'b1;
		end

		if (commit)
		begin
			st_nxt.last_wr = rx_wr;
			st_nxt.last_addr = rx_addr;
			// status and diagnostics are not plain storage
			if (rx_wr && (rx_addr < ADDR_LIMIT) && (rx_addr != ADDR_STATUS)
				&& (rx_addr != ADDR_DIAG))
			begin
				st_nxt.bank[rx_addr[3:0]] = rx_data;
			end
		end

		// live faults only: a latched but recovered fault does not hold the pin
		st_nxt.ffo_n = ~(|st_r.f2[NUM_FAULTS-1:0]);
		st_nxt.rail_n = ~st_r.f2[NUM_FAULTS];
	end

	// whole state in one register; reset values come from the constant above
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= DEV_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign link.sdo_out = st_r.tx[FF_BIT];
	assign link.sdo_oe = st_r.sdo_oe;
	// one drives the upper half on, zero the lower half
	assign gate_drive_out = st_r.bank[ADDR_GATE[3:0]][NUM_GATES-1:0];
	assign fault_output_n = st_r.ffo_n;
	assign main_rail_reset_n = st_r.rail_n;
	assign serial_error_flag = st_r.diag[DIAG_SE];
endmodule : srg_device
`default_nettype wire

//--- core/srg_host.sv
// host end of the serial link, commanded by software over apb
// assumes one device on the strobe; sck is made here by a divider
`timescale 1ns/1ps
`default_nettype none
module srg_host (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [srg_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	srg_link_if.host link
);
	import srg_pkg::*;

	typedef struct packed {
		srg_hstate_t state;
		logic [4:0] div;
		logic [4:0] bitn;
		logic [FRAME_BITS-1:0] txw;
		logic [FRAME_BITS-1:0] rxw;
		logic [FRAME_BITS-1:0] rx_last;
		logic done;
		logic s1;
		logic s2;
		logic strobe_n;
		logic sck;
		logic sdi;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} srg_host_st_t;

	localparam srg_host_st_t HOST_RST = '{
		state: HS_IDLE,
		strobe_n: 1'b1,
		sck: 1'b1,
		default: '0
	};

	srg_host_st_t st_r;
	srg_host_st_t st_nxt;
	logic setup;
	logic access;
	logic half_end;
	logic [FRAME_BITS-2:0] body;

	assign setup = psel & ~penable;
	assign access = psel & penable & st_r.pready;
	assign half_end = (st_r.div == HALF_LAST);
	assign body = {pwdata[CMD_ADDR_LSB+ADDR_W-1:CMD_ADDR_LSB], pwdata[CMD_WR_BIT], 1'b0,
		pwdata[DATA_W-1:0]};

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = link.sdo;
		st_nxt.s2 = st_r.s1;
		st_nxt.pready = setup;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = '0;
		if (setup)
		begin
			if (paddr == HREG_STAT)
			begin
				st_nxt.prdata[STAT_BUSY] = (st_r.state != HS_IDLE);
				st_nxt.prdata[STAT_DONE] = st_r.done;
				st_nxt.prdata[STAT_PAR_OK] = ^st_r.rx_last;
			end
			else if (paddr == HREG_RX)
			begin
				st_nxt.prdata[FRAME_BITS-1:0] = st_r.rx_last;
			end
			else if (paddr != HREG_CMD)
			begin
				st_nxt.pslverr = 1'b1;
			end
		end

		if (st_r.state != HS_IDLE)
		begin
			st_nxt.div = half_end ? 5'h00 : st_r.div + 5'h01;
		end
		case (st_r.state)
			HS_IDLE:
			begin
				// a command while busy is dropped without error
				if (access && pwrite && (paddr == HREG_CMD))
				begin
					st_nxt.txw = {body, srg_odd_par(body)};
					st_nxt.strobe_n = 1'b0;
					st_nxt.div = '0;
					st_nxt.bitn = '0;
					st_nxt.done = 1'b0;
					st_nxt.state = HS_LEAD;
				end
			end
			HS_LEAD, HS_HIGH:
			begin
				if (half_end && (st_r.bitn == CNT_FULL))
				begin
					st_nxt.strobe_n = 1'b1;
					st_nxt.rx_last = st_r.rxw;
					st_nxt.done = 1'b1;
					st_nxt.state = HS_GAP;
				end
				else if (half_end)
				begin
					// sample before the fall that advances the reply
					st_nxt.rxw = {st_r.rxw[FRAME_BITS-2:0], st_r.s2};
					st_nxt.sck = 1'b0;
					st_nxt.sdi = st_r.txw[FRAME_BITS-1];
					st_nxt.txw = {st_r.txw[FRAME_BITS-2:0], 1'b0};
					st_nxt.state = HS_LOW;
				end
			end
			HS_LOW:
			begin
				if (half_end)
				begin
					st_nxt.sck = 1'b1;
					st_nxt.bitn = st_r.bitn + 5'h01;
					st_nxt.state = HS_HIGH;
				end
			end
			HS_GAP:
			begin
				if (half_end)
				begin
					st_nxt.state = HS_IDLE;
				end
			end
			default:
			begin
				st_nxt.state = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= HOST_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign link.serial_strobe_n = st_r.strobe_n;
	assign link.sck = st_r.sck;
	assign link.sdi = st_r.sdi;
endmodule : srg_host
`default_nettype wire

//--- core/srg_link_if.sv
// serial link between the host controller and the register device
// the bench resolves nothing: sdo is worked out here from the enable
`timescale 1ns/1ps
`default_nettype none
interface srg_link_if;
	logic serial_strobe_n;
	logic sck;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	wire sdo;

	// a released line reads inverted, so a late sample shows up as a wrong bit
	assign sdo = sdo_oe ? sdo_out : ~sdo_out;

	modport dev (
		input serial_strobe_n,
		input sck,
		input sdi,
		output sdo_out,
		output sdo_oe
	);
	modport host (
		output serial_strobe_n,
		output sck,
		output sdi,
		input sdo
	);
endinterface : srg_link_if
`default_nettype wire

//--- core/srg_pkg.sv
// shared constants and types for the serial register gate link
// assumes a 200 MHz system clock on both ends of the link
`default_nettype none
package srg_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCK_PERIOD_NS = 160;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [4:0] HALF_LAST = 5'(SCK_HALF_CYC - 1);

	localparam int FRAME_BITS = 16;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_BANKS = 15;
	localparam int NUM_GATES = 4;
	localparam int NUM_FAULTS = 7;

	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 11;
	localparam int WR_BIT = 10;
	localparam int DATA_MSB = 8;
	localparam int DATA_LSB = 1;
	localparam int FF_BIT = 15;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_OVER = 5'h11;

	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_DIAG = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_GATE = 5'h07;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT = 5'h0F;
	localparam int DIAG_SE = 0;

	localparam int IX_STB = 0;
	localparam int IX_SCK = 1;
	localparam int IX_SDI = 2;
	localparam logic [2:0] SYNC_IDLE = 3'h3;

	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] HREG_CMD = 12'h000;
	localparam logic [APB_AW-1:0] HREG_STAT = 12'h004;
	localparam logic [APB_AW-1:0] HREG_RX = 12'h008;
	localparam int CMD_WR_BIT = 13;
	localparam int CMD_ADDR_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_PAR_OK = 2;

	typedef enum {HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_GAP} srg_hstate_t;

	// odd parity over the fifteen leading frame bits
	function automatic logic srg_odd_par(input logic [FRAME_BITS-2:0] v);
		return ~^v;
	endfunction : srg_odd_par
endpackage : srg_pkg
`default_nettype wire

//--- tb/srg_link_asserts.sv
// assertions on the serial link joining host and device
// assumes sck comes from the host divider in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module srg_link_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic serial_strobe_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe
);
	logic [4:0] rises_r;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	sequence frame_open;
		$fell(serial_strobe_n);
	endsequence
	sequence frame_close;
		$rose(serial_strobe_n);
	endsequence
	// held until the strobe rise is sampled, so the count is still visible there
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rises_r <= 5'h00;
		else if (serial_strobe_n)
			rises_r <= 5'h00;
		else if ($rose(sck))
			rises_r <= rises_r + 5'h01;
	end
	chk_oe_rise: assert property (frame_open |-> ##[1:5] sdo_oe)
		else $error("reply enable late");
	chk_oe_idle: assert property (serial_strobe_n [*6] |-> !sdo_oe)
		else $error("reply driven while idle");
	chk_sdo_step: assert property (!serial_strobe_n && sdo_oe && $past(sdo_oe)
		&& $changed(sdo_out) |-> !sck) else $error("reply bit moved with sck high");
	chk_sdi_hold: assert property ($rose(sck) |-> $stable(sdi))
		else $error("sdi moved at sck rise");
	chk_sck_strobe: assert property ($changed(serial_strobe_n) |-> sck && $past(sck))
		else $error("strobe moved with sck low");
	chk_sck_frame: assert property ($changed(sck) |-> !serial_strobe_n)
		else $error("sck moved outside a frame");
	chk_gap_idle: assert property (frame_close |-> serial_strobe_n [*8])
		else $error("strobe gap too short");
	chk_bit_count: assert property (frame_close |-> rises_r == 5'h10)
		else $error("frame without sixteen rises");
endmodule : srg_link_asserts
`default_nettype wire

//--- tb/tb_spi_register_access_gate_ctrl.sv
// bench: apb-driven host against one device, and a second device on a
// hand-driven link that breaks the framing on purpose
`timescale 1ns/1ps
`default_nettype none
module tb_spi_register_access_gate_ctrl;
	import srg_pkg::*;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, qe;
	logic main_rail_fault, fon, rstn_a, se_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [6:0] fault_src;
	logic [3:0] gate_a, gate_b;
	int errors, n_compared;
	srg_link_if link();
	srg_link_if link2();
	srg_host u_srg_host (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .link(link));
	srg_device u_srg_device (.sys_clk, .nrst, .link(link), .fault_src, .main_rail_fault,
		.gate_drive_out(gate_a), .fault_output_n(fon), .main_rail_reset_n(rstn_a),
		.serial_error_flag());
	srg_device u_srg_device_2 (.sys_clk, .nrst, .link(link2), .fault_src(7'h00),
		.main_rail_fault(1'h0), .gate_drive_out(gate_b), .fault_output_n(),
		.main_rail_reset_n(), .serial_error_flag(se_b));
	srg_link_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst),
		.serial_strobe_n(link.serial_strobe_n), .sck(link.sck), .sdi(link.sdi),
		.sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe));
	initial
	begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] rw(input logic ff, input logic [7:0] d);
		return {ff, 6'h00, d, ~^{ff, d}};
	endfunction : rw
	function automatic logic [15:0] fw(input logic [4:0] a, input logic [7:0] d);
		return {a, 2'h2, d, ~^{a, 1'h1, d}};
	endfunction : fw
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic limit(input int i, input int n);
		if (i >= n)
		begin
			errors++;
			test_done();
		end
	endtask : limit
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (pready !== 1'h1 && i < 50);
		limit(i, 50);
		q = prdata;
		qe = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// one host frame; the reply belongs to the frame before it
	task automatic frame(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [15:0] rep);
		int i;
		apb(1'h1, HREG_CMD, 32'({w, a, d}));
		i = 0;
		do
		begin
			apb(1'h0, HREG_STAT, 32'h0);
			i++;
		end
		while ((q[STAT_BUSY] !== 1'h0 || q[STAT_DONE] !== 1'h1) && i < 500);
		limit(i, 500);
		apb(1'h0, HREG_RX, 32'h0);
		chk(32'(q[15:0]), 32'(rep));
	endtask : frame
	// stands in for the host on the second link, n sck rises per frame
	task automatic bang(input logic [15:0] w, input int n, input logic [4:0] exp);
		@(posedge sys_clk);
		link2.serial_strobe_n <= 1'h0;
		repeat (n)
		begin
			repeat (16) @(posedge sys_clk);
			link2.sck <= 1'h0;
			link2.sdi <= w[15];
			w = w << 1;
			repeat (16) @(posedge sys_clk);
			link2.sck <= 1'h1;
		end
		repeat (16) @(posedge sys_clk);
		link2.serial_strobe_n <= 1'h1;
		link2.sdi <= 1'h0;
		repeat (32) @(posedge sys_clk);
		chk(32'(link2.sdo_oe), 32'h0);
		chk({27'h0, se_b, gate_b}, {27'h0, exp});
	endtask : bang
	task automatic t_gates;
		apb(1'h0, 12'h00C, 32'h0);
		chk(32'(qe), 32'h1);
		frame(1'h1, ADDR_GATE, 8'h0A, rw(1'h0, 8'h00));
		chk(32'(gate_a), 32'h0A);
		frame(1'h0, ADDR_GATE, 8'h00, rw(1'h0, 8'h00));
		frame(1'h0, 5'h03, 8'h55, rw(1'h0, 8'h0A));
		frame(1'h0, ADDR_GATE, 8'h55, rw(1'h0, 8'h00));
		chk(32'(gate_a), 32'h0A);
	endtask : t_gates
	task automatic t_faults;
		fault_src <= 7'h01;
		main_rail_fault <= 1'h1;
		repeat (10) @(posedge sys_clk);
		chk({30'h0, fon, rstn_a}, 32'h0);
		frame(1'h1, ADDR_GATE, 8'h05, rw(1'h1, 8'h0A));
		chk(32'(gate_a), 32'h05);
		fault_src <= 7'h00;
		main_rail_fault <= 1'h0;
		repeat (10) @(posedge sys_clk);
		chk({30'h0, fon, rstn_a}, 32'h3);
		frame(1'h0, ADDR_DIAG, 8'h00, rw(1'h1, 8'h02));
		frame(1'h0, ADDR_STATUS, 8'h00, rw(1'h0, 8'h00));
	endtask : t_faults
	task automatic t_framing;
		bang(fw(ADDR_GATE, 8'h03), 16, 5'h03);
		bang(fw(ADDR_GATE, 8'h0C), 15, 5'h13);
		bang(fw(ADDR_GATE, 8'h06), 16, 5'h06);
		bang(fw(ADDR_GATE, 8'h09) ^ 16'h0001, 16, 5'h16);
		repeat (8)
		begin
			repeat (4) @(posedge sys_clk);
			link2.sck <= ~link2.sck;
			link2.sdi <= ~link2.sdi;
		end
		repeat (16) @(posedge sys_clk);
		bang(fw(ADDR_GATE, 8'h0A), 16, 5'h0A);
		bang(fw(ADDR_GATE, 8'h0C), 17, 5'h1A);
	endtask : t_framing
	initial
	begin
		errors = 0;
		n_compared = 0;
		nrst = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fault_src = 7'h00;
		main_rail_fault = 1'h0;
		link2.serial_strobe_n = 1'h1;
		link2.sck = 1'h1;
		link2.sdi = 1'h0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'h1;
		t_gates();
		t_faults();
		t_framing();
		test_done();
	end
endmodule : tb_spi_register_access_gate_ctrl
`default_nettype wire
